/* logic/pqp_cfg.svh */
// What this block does
// - Each of the eight received priorities picks one of four queues via a 2-bit entry.
// - Untagged frames get a tag of default VLAN id, canonical flag and priority.
// - Four 12-bit receive queue limits, two per register, in 4K-byte units.
// - A queue limit field of all ones turns that queue's limiting off; this is the reset value.
// - Four 12-bit transmit queue limits, two per register, in 4K-byte units.
// - Two 12-bit whole-port ingress and egress limits give bytes allowed per window.
// - A port limit field of all ones turns that port limit off; this is the reset value.
// - The window is a 27-bit cycle count, resetting to one second at 10 ns.
// - With flow control on and pause inactive, a page count above the high mark requests pause-on.
// - With flow control on and pause active, a page count below the low mark requests pause-off.
// - Four 4-bit queue weights reset to all ones; queue 0 at all ones turns weighting off.
// - Weighted scheduling counts 128-byte pages, not packets.
// - A 48-bit expected destination spans two registers, top byte in bits 7:0 of the first.
// - With destination matching on, unicast frames to other addresses are dropped.
// - Port ingress and egress limiting each act only while their own enable bit is set.
`ifndef PQP_CFG_SVH
`define PQP_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define PQP_OFF_QMAP 12'h284
`define PQP_OFF_DTAG 12'h288
`define PQP_OFF_RXLIM_LO 12'h28c
`define PQP_OFF_RXLIM_HI 12'h290
`define PQP_OFF_TXLIM_LO 12'h294
`define PQP_OFF_TXLIM_HI 12'h298
`define PQP_OFF_PLIM 12'h29c
`define PQP_OFF_WIN 12'h2a0
`define PQP_OFF_WMARK 12'h2a4
`define PQP_OFF_WEIGHT 12'h2a8
`define PQP_OFF_DMAC_HI 12'h2b0
`define PQP_OFF_DMAC_LO 12'h2b4
`define PQP_OFF_CTRL 12'h2c0
`define PQP_OFF_STAT 12'h2c4

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define PQP_HI_LSB 16
`define PQP_CTRL_FC 0
`define PQP_CTRL_RXEN 16
`define PQP_CTRL_TXEN 17
`define PQP_CTRL_DMEN 18
`define PQP_RST_QMAP 16'hfa50
`define PQP_RST_DTAG 16'h0001
`define PQP_LIM_OFF 12'hfff
`define PQP_RST_WIN 27'h5f5_e100
`define PQP_RST_HIMARK 8'h28
`define PQP_RST_LOMARK 8'h14
`define PQP_RST_WEIGHT 16'hffff
`define PQP_WEIGHT_OFF 4'hf
`define PQP_PAGE_SHIFT 7
`define PQP_PAGE_ROUND 16'h007f
`define PQP_MCAST_BIT 40
`define PQP_FIFO_DEPTH 16

`endif

/* logic/pqp_pkg.sv */
package pqp_pkg;

    typedef struct packed {
        logic [15:0] qmap;
        logic [15:0] dtag;
        logic [3:0][11:0] rxlim;
        logic [3:0][11:0] txlim;
        logic [11:0] plim_in;
        logic [11:0] plim_eg;
        logic [26:0] win_len;
        logic [7:0] himark;
        logic [7:0] lomark;
        logic [15:0] weights;
        logic [47:0] dmac;
        logic fc_en;
        logic rx_en;
        logic tx_en;
        logic dm_en;
        logic [26:0] win_cnt;
        logic [3:0][24:0] rx_acc;
        logic [3:0][24:0] tx_acc;
        logic [24:0] rx_pacc;
        logic [24:0] tx_pacc;
        logic [3:0][15:0] pages;
        logic pause_active;
        logic pause_on;
        logic pause_off;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } pqp_state_t;

    typedef enum logic [1:0] {
        PQP_RESP_OKAY = 2'b00,
        PQP_RESP_SLVERR = 2'b10
    } pqp_resp_t;

endpackage

/* logic/pqp_top.sv */
`timescale 1ns/100ps
`include "pqp_cfg.svh"

// ----------------------------------------
// Descriptor FIFO
// ----------------------------------------
module pqp_fifo #(
    parameter int W = 35,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } pqp_fifo_st_t;

    pqp_fifo_st_t st_reg;
    pqp_fifo_st_t st_next;
    logic push;
    logic pop;

    assign in_ready = st_reg.cnt != FULL;
    assign out_valid = st_reg.cnt != '0;
    assign out_data = st_reg.mem[st_reg.rp];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wp] = in_data;
            st_next.wp = st_reg.wp + 1'b1;
        end
        if (pop) begin
            st_next.rp = st_reg.rp + 1'b1;
        end
        if (push && !pop) begin
            st_next.cnt = st_reg.cnt + 1'b1;
        end else if (pop && !push) begin
            st_next.cnt = st_reg.cnt - 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    property p_fifo_full;
        @(posedge core_clk) disable iff (!rst_n)
        (st_reg.cnt == FULL) && !pop |-> !in_ready ##1 st_reg.cnt == FULL;
    endproperty
    a_fifo_full: assert property (p_fifo_full) else $error("fifo took data while full");
endmodule

// ----------------------------------------
// Port policy block
// ----------------------------------------
module pqp_top #(
    parameter int FIFO_W = 35,
    parameter int FIFO_DEPTH = `PQP_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // AXI4-Lite slave
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Receive frame descriptors
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [2:0] rx_prio,
    input wire logic rx_tagged,
    input wire logic [47:0] rx_dest,
    input wire logic [15:0] rx_len,
    // Queued descriptors to buffer manager
    output logic q_valid,
    input wire logic q_ready,
    output logic [FIFO_W-1:0] q_data,
    // Transmit frame descriptors
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [1:0] tx_queue,
    input wire logic [15:0] tx_len,
    // Flow control
    input wire logic [7:0] rx_page_count,
    output logic pause_on_req,
    output logic pause_off_req,
    output logic pause_active,
    // Scheduler settings
    output logic [15:0] sched_weights,
    output logic weighted_sched_en,
    output logic [63:0] sched_pages
);
    pqp_pkg::pqp_state_t st_reg;
    pqp_pkg::pqp_state_t st_next;

    logic wr_fire;
    logic rd_fire;
    logic [32:0] wr_old;
    logic [32:0] rd_word;
    logic [31:0] bmask;
    logic [31:0] wval;
    logic [2:0] eff_prio;
    logic [1:0] rx_q;
    logic rx_q_hit;
    logic rx_p_hit;
    logic dm_drop;
    logic rx_hold;
    logic rx_push;
    logic fifo_in_ready;
    logic tx_q_hit;
    logic tx_p_hit;
    logic tx_fire;
    logic win_tick;
    logic [27:0] win_cnt_inc;
    logic [16:0] tx_pg_sum;
    logic [15:0] tx_pg;
    logic [FIFO_W-1:0] rx_word;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic lim_hit(input logic [24:0] acc, input logic [11:0] lim);
        lim_hit = (lim != `PQP_LIM_OFF) && (acc >= {1'b0, lim, 12'h000});
    endfunction

    // Saturates once bit 24 is set, just above the largest 12-bit limit
    function automatic logic [24:0] acc_add(input logic [24:0] acc, input logic [15:0] len);
        acc_add = acc[24] ? acc : acc + {9'h000, len};
    endfunction

    // Read view; unused and reserved bits are zero
    function automatic logic [32:0] reg_read(input pqp_pkg::pqp_state_t s,
                                             input logic [11:0] a);
        reg_read = '0;
        case ({a[11:2], 2'b00})
            `PQP_OFF_QMAP: reg_read = {1'b1, 16'h0000, s.qmap};
            `PQP_OFF_DTAG: reg_read = {1'b1, 16'h0000, s.dtag};
            `PQP_OFF_RXLIM_LO: reg_read = {1'b1, 4'h0, s.rxlim[1], 4'h0, s.rxlim[0]};
            `PQP_OFF_RXLIM_HI: reg_read = {1'b1, 4'h0, s.rxlim[3], 4'h0, s.rxlim[2]};
            `PQP_OFF_TXLIM_LO: reg_read = {1'b1, 4'h0, s.txlim[1], 4'h0, s.txlim[0]};
            `PQP_OFF_TXLIM_HI: reg_read = {1'b1, 4'h0, s.txlim[3], 4'h0, s.txlim[2]};
            `PQP_OFF_PLIM: reg_read = {1'b1, 4'h0, s.plim_eg, 4'h0, s.plim_in};
            `PQP_OFF_WIN: reg_read = {1'b1, 5'h00, s.win_len};
            `PQP_OFF_WMARK: reg_read = {1'b1, 16'h0000, s.lomark, s.himark};
            `PQP_OFF_WEIGHT: reg_read = {1'b1, 16'h0000, s.weights};
            `PQP_OFF_DMAC_HI: reg_read = {1'b1, s.dmac[23:16], s.dmac[31:24],
                                          s.dmac[39:32], s.dmac[47:40]};
            `PQP_OFF_DMAC_LO: reg_read = {1'b1, 16'h0000, s.dmac[7:0], s.dmac[15:8]};
            `PQP_OFF_CTRL: reg_read = {1'b1, 13'h0000, s.dm_en, s.tx_en, s.rx_en,
                                       15'h0000, s.fc_en};
            `PQP_OFF_STAT: reg_read = {1'b1, 31'h0000_0000, s.pause_active};
            default: reg_read = '0;
        endcase
    endfunction

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    // Write address and data are taken together, one write at a time
    assign wr_fire = s_axi_awvalid && s_axi_wvalid && !st_reg.bvalid;
    assign s_axi_awready = wr_fire;
    assign s_axi_wready = wr_fire;
    assign rd_fire = s_axi_arvalid && !st_reg.rvalid;
    assign s_axi_arready = rd_fire;
    assign wr_old = reg_read(st_reg, s_axi_awaddr[11:0]);
    assign rd_word = reg_read(st_reg, s_axi_araddr[11:0]);
    assign bmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                    {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    assign wval = (wr_old[31:0] & ~bmask) | (s_axi_wdata & bmask);

    // ----------------------------------------
    // Receive path
    // ----------------------------------------
    assign eff_prio = rx_tagged ? rx_prio : st_reg.dtag[15:13];
    assign rx_q = st_reg.qmap[{eff_prio, 1'b0} +: 2];
    assign dm_drop = st_reg.dm_en && !rx_dest[`PQP_MCAST_BIT]
                     && (rx_dest != st_reg.dmac);
    assign rx_q_hit = lim_hit(st_reg.rx_acc[rx_q], st_reg.rxlim[rx_q]);
    assign rx_p_hit = st_reg.rx_en && lim_hit(st_reg.rx_pacc, st_reg.plim_in);
    assign rx_hold = !dm_drop && (rx_q_hit || rx_p_hit);
    // Dropped frames are consumed at once; held ones wait for the next window
    assign rx_ready = dm_drop || (!rx_hold && fifo_in_ready);
    assign rx_push = rx_valid && !dm_drop && !rx_hold;
    // Word: queue, insert flag, tag to insert, length
    assign rx_word = {rx_q, !rx_tagged, st_reg.dtag, rx_len};

    pqp_fifo #(
        .W(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .in_valid(rx_push),
        .in_ready(fifo_in_ready),
        .in_data(rx_word),
        .out_valid(q_valid),
        .out_ready(q_ready),
        .out_data(q_data)
    );

    // ----------------------------------------
    // Transmit path
    // ----------------------------------------
    assign tx_q_hit = lim_hit(st_reg.tx_acc[tx_queue], st_reg.txlim[tx_queue]);
    assign tx_p_hit = st_reg.tx_en && lim_hit(st_reg.tx_pacc, st_reg.plim_eg);
    assign tx_ready = !(tx_q_hit || tx_p_hit);
    assign tx_fire = tx_valid && tx_ready;
    assign tx_pg_sum = {1'b0, tx_len} + {1'b0, `PQP_PAGE_ROUND};
    assign tx_pg = 16'(tx_pg_sum >> `PQP_PAGE_SHIFT);

    // ----------------------------------------
    // Window timer
    // ----------------------------------------
    assign win_cnt_inc = {1'b0, st_reg.win_cnt} + 28'h000_0001;
    assign win_tick = win_cnt_inc >= {1'b0, st_reg.win_len};

    always_comb begin
        st_next = st_reg;
        st_next.pause_on = 1'b0;
        st_next.pause_off = 1'b0;
        // Bus answers
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        if (rd_fire) begin
            st_next.rvalid = 1'b1;
            st_next.rdata = rd_word[31:0];
            st_next.rresp = rd_word[32] ? pqp_pkg::PQP_RESP_OKAY : pqp_pkg::PQP_RESP_SLVERR;
        end
        if (wr_fire) begin
            st_next.bvalid = 1'b1;
            st_next.bresp = wr_old[32] ? pqp_pkg::PQP_RESP_OKAY : pqp_pkg::PQP_RESP_SLVERR;
            // Only defined fields are stored, reserved bits drop out
            case ({s_axi_awaddr[11:2], 2'b00})
                `PQP_OFF_QMAP: st_next.qmap = wval[15:0];
                `PQP_OFF_DTAG: st_next.dtag = wval[15:0];
                `PQP_OFF_RXLIM_LO: st_next.rxlim[1:0] = {wval[27:16], wval[11:0]};
                `PQP_OFF_RXLIM_HI: st_next.rxlim[3:2] = {wval[27:16], wval[11:0]};
                `PQP_OFF_TXLIM_LO: st_next.txlim[1:0] = {wval[27:16], wval[11:0]};
                `PQP_OFF_TXLIM_HI: st_next.txlim[3:2] = {wval[27:16], wval[11:0]};
                `PQP_OFF_PLIM: begin
                    st_next.plim_in = wval[11:0];
                    st_next.plim_eg = wval[27:16];
                end
                `PQP_OFF_WIN: st_next.win_len = wval[26:0];
                `PQP_OFF_WMARK: {st_next.lomark, st_next.himark} = wval[15:0];
                `PQP_OFF_WEIGHT: st_next.weights = wval[15:0];
                `PQP_OFF_DMAC_HI: st_next.dmac[47:16] = {wval[7:0], wval[15:8],
                                                         wval[23:16], wval[31:24]};
                `PQP_OFF_DMAC_LO: st_next.dmac[15:0] = {wval[7:0], wval[15:8]};
                `PQP_OFF_CTRL: begin
                    st_next.fc_en = wval[`PQP_CTRL_FC];
                    st_next.rx_en = wval[`PQP_CTRL_RXEN];
                    st_next.tx_en = wval[`PQP_CTRL_TXEN];
                    st_next.dm_en = wval[`PQP_CTRL_DMEN];
                end
                default: st_next.bresp = pqp_pkg::PQP_RESP_SLVERR;
            endcase
        end
        // Byte accounting
        if (rx_push && fifo_in_ready) begin
            st_next.rx_acc[rx_q] = acc_add(st_reg.rx_acc[rx_q], rx_len);
            st_next.rx_pacc = acc_add(st_reg.rx_pacc, rx_len);
        end
        if (tx_fire) begin
            st_next.tx_acc[tx_queue] = acc_add(st_reg.tx_acc[tx_queue], tx_len);
            st_next.tx_pacc = acc_add(st_reg.tx_pacc, tx_len);
            if (st_reg.pages[tx_queue] != 16'hffff) begin
                st_next.pages[tx_queue] = st_reg.pages[tx_queue] + tx_pg;
            end
        end
        // Window end clears all counts; traffic in that cycle is forgiven
        if (win_tick) begin
            st_next.win_cnt = '0;
            st_next.rx_acc = '0;
            st_next.tx_acc = '0;
            st_next.rx_pacc = '0;
            st_next.tx_pacc = '0;
            st_next.pages = '0;
        end else begin
            st_next.win_cnt = win_cnt_inc[26:0];
        end
        // Pause watermarks
        if (!st_reg.fc_en) begin
            st_next.pause_active = 1'b0;
        end else if (!st_reg.pause_active && rx_page_count > st_reg.himark) begin
            st_next.pause_active = 1'b1;
            st_next.pause_on = 1'b1;
        end else if (st_reg.pause_active && rx_page_count < st_reg.lomark) begin
            st_next.pause_active = 1'b0;
            st_next.pause_off = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
            st_reg.qmap <= `PQP_RST_QMAP;
            st_reg.dtag <= `PQP_RST_DTAG;
            st_reg.rxlim <= {4{`PQP_LIM_OFF}};
            st_reg.txlim <= {4{`PQP_LIM_OFF}};
            st_reg.plim_in <= `PQP_LIM_OFF;
            st_reg.plim_eg <= `PQP_LIM_OFF;
            st_reg.win_len <= `PQP_RST_WIN;
            st_reg.himark <= `PQP_RST_HIMARK;
            st_reg.lomark <= `PQP_RST_LOMARK;
            st_reg.weights <= `PQP_RST_WEIGHT;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rresp = st_reg.rresp;
    assign s_axi_rdata = st_reg.rdata;
    assign pause_on_req = st_reg.pause_on;
    assign pause_off_req = st_reg.pause_off;
    assign pause_active = st_reg.pause_active;
    assign sched_weights = st_reg.weights;
    assign weighted_sched_en = st_reg.weights[3:0] != `PQP_WEIGHT_OFF;
    assign sched_pages = st_reg.pages;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_map_queue;
        @(posedge core_clk) disable iff (!rst_n)
        rx_valid && rx_ready && !dm_drop |-> rx_word[34:33] == st_reg.qmap[{eff_prio, 1'b0} +: 2];
    endproperty
    a_map_queue: assert property (p_map_queue) else $error("queue not from map");

    property p_dm_drop;
        @(posedge core_clk) disable iff (!rst_n)
        rx_valid && st_reg.dm_en && !rx_dest[40] && rx_dest != st_reg.dmac |-> rx_ready && !rx_push;
    endproperty
    a_dm_drop: assert property (p_dm_drop) else $error("foreign unicast not dropped");

    property p_rx_hold;
        @(posedge core_clk) disable iff (!rst_n)
        st_reg.rxlim[rx_q] != 12'hfff && st_reg.rx_acc[rx_q] >= {1'b0, st_reg.rxlim[rx_q], 12'h000}
        && !dm_drop |-> !rx_ready;
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("queue over limit accepted");

    property p_port_enable;
        @(posedge core_clk) disable iff (!rst_n)
        !st_reg.tx_en && tx_ready == 1'b0 |-> tx_q_hit;
    endproperty
    a_port_enable: assert property (p_port_enable) else $error("port limit while off");

    property p_window;
        @(posedge core_clk) disable iff (!rst_n)
        win_tick |=> st_reg.win_cnt == 27'h000_0000 && st_reg.rx_pacc == 25'h000_0000;
    endproperty
    a_window: assert property (p_window) else $error("window end did not clear");

    property p_pause_on;
        @(posedge core_clk) disable iff (!rst_n)
        st_reg.fc_en && !st_reg.pause_active && rx_page_count > st_reg.himark
        |=> pause_on_req && pause_active ##1 !pause_on_req;
    endproperty
    a_pause_on: assert property (p_pause_on) else $error("pause on missing");

    property p_pause_off;
        @(posedge core_clk) disable iff (!rst_n)
        st_reg.fc_en && st_reg.pause_active && rx_page_count < st_reg.lomark
        |=> pause_off_req && !pause_active;
    endproperty
    a_pause_off: assert property (p_pause_off) else $error("pause off missing");

    property p_write_resp;
        @(posedge core_clk) disable iff (!rst_n)
        wr_fire |=> s_axi_bvalid && !s_axi_awready;
    endproperty
    a_write_resp: assert property (p_write_resp) else $error("write not answered");

    property p_read_zero;
        @(posedge core_clk) disable iff (!rst_n)
        rd_fire && s_axi_araddr[11:0] == 12'h28c |=> s_axi_rvalid && s_axi_rdata[31:28] == 4'h0
        && s_axi_rdata[15:12] == 4'h0;
    endproperty
    a_read_zero: assert property (p_read_zero) else $error("reserved bits read nonzero");
endmodule

/* verif/pqp_bm_model.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Buffer manager stand-in
// ----------------------------------------
module pqp_bm_model (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Descriptor stream
    input wire logic q_valid,
    output logic q_ready,
    input wire logic [34:0] q_data,
    // Bench control and view
    input wire logic hold,
    output logic [7:0] got,
    output logic [34:0] last
);
    // Stalls on request so the FIFO can be driven to refusal
    assign q_ready = !hold;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            got <= 8'h00;
            last <= '0;
        end else if (q_valid && q_ready) begin
            got <= got + 8'h01;
            last <= q_data;
        end
    end
endmodule

/* verif/pqp_top_bench.sv */
`timescale 1ns/100ps
// ----------------------------------------
// Bench
// ----------------------------------------
module pqp_top_bench;
    typedef struct packed {logic [11:0] a; logic [31:0] r; logic [31:0] o;} pqp_row_t;
    logic core_clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, rx_valid, rx_ready, rx_tagged, q_valid;
    logic q_ready, tx_valid, tx_ready, hold, pon, poff, pact, wen;
    logic [31:0] awaddr, araddr, wdata, rdata, rdv;
    logic [1:0] bresp, rresp, rsp, tx_queue;
    logic [2:0] rx_prio;
    logic [47:0] rx_dest;
    logic [15:0] rx_len, tx_len, sched_weights;
    logic [34:0] q_data, last;
    logic [7:0] rx_page_count, got;
    logic [63:0] spages;
    int err_total, tests_run, i;
    pqp_row_t rows [12] = '{{12'h284, 32'h0000_fa50, 32'h0000_ffff},
        {12'h288, 32'h0000_0001, 32'h0000_ffff}, {12'h28c, 32'h0fff_0fff, 32'h0fff_0fff},
        {12'h290, 32'h0fff_0fff, 32'h0fff_0fff}, {12'h294, 32'h0fff_0fff, 32'h0fff_0fff},
        {12'h298, 32'h0fff_0fff, 32'h0fff_0fff}, {12'h29c, 32'h0fff_0fff, 32'h0fff_0fff},
        {12'h2a0, 32'h05f5_e100, 32'h07ff_ffff}, {12'h2a4, 32'h0000_1428, 32'h0000_ffff},
        {12'h2a8, 32'h0000_ffff, 32'h0000_ffff}, {12'h2b0, 32'h0000_0000, 32'hffff_ffff},
        {12'h2b4, 32'h0000_0000, 32'h0000_ffff}};

    pqp_top dut (.core_clk(core_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_prio(rx_prio),
        .rx_tagged(rx_tagged), .rx_dest(rx_dest), .rx_len(rx_len), .q_valid(q_valid),
        .q_ready(q_ready), .q_data(q_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_queue(tx_queue), .tx_len(tx_len), .rx_page_count(rx_page_count),
        .pause_on_req(pon), .pause_off_req(poff), .pause_active(pact),
        .sched_weights(sched_weights), .weighted_sched_en(wen), .sched_pages(spages));
    pqp_bm_model bm (.core_clk(core_clk), .rst_n(rst_n), .q_valid(q_valid),
        .q_ready(q_ready), .q_data(q_data), .hold(hold), .got(got), .last(last));

    task chk(input logic [47:0] s, input logic [47:0] e);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // Handshakes are judged at the falling edge, where every output has settled
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        awaddr <= {20'h0_0000, a};
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'b111;
        do @(negedge core_clk); while (!(awready && wready));
        @(posedge core_clk);
        {awvalid, wvalid} <= 2'b00;
        do @(negedge core_clk); while (!bvalid);
        @(posedge core_clk);
        bready <= 1'b0;
    endtask
    task rd(input logic [11:0] a);
        @(posedge core_clk);
        araddr <= {20'h0_0000, a};
        {arvalid, rready} <= 2'b11;
        do @(negedge core_clk); while (!arready);
        @(posedge core_clk);
        arvalid <= 1'b0;
        do @(negedge core_clk); while (!rvalid);
        {rsp, rdv} = {rresp, rdata};
        @(posedge core_clk);
        rready <= 1'b0;
    endtask
    task snd(input logic [2:0] p, input logic t, input logic [47:0] d, input logic [15:0] l);
        @(posedge core_clk);
        {rx_prio, rx_tagged, rx_dest, rx_len, rx_valid} <= {p, t, d, l, 1'b1};
        do @(negedge core_clk); while (!rx_ready);
        @(posedge core_clk);
        rx_valid <= 1'b0;
    endtask
    task wg(input int e);
        for (int k = 0; k < 20 && got != e; k++) @(negedge core_clk);
    endtask
    task end_sim();
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        end_sim();
    end
    initial begin
        {rst_n, awvalid, wvalid, bready, arvalid, rready, rx_valid, tx_valid, hold} = '0;
        {awaddr, araddr, wdata, rx_prio, rx_tagged, rx_dest, rx_len} = '0;
        {tx_queue, tx_len, rx_page_count} = '0;
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        chk({wen, pact}, 2'b00);
        for (i = 0; i < 12; i++) begin
            rd(rows[i].a);
            chk(rdv, rows[i].r);
            wr(rows[i].a, 32'hffff_ffff);
            rd(rows[i].a);
            chk(rdv, rows[i].o);
        end
        rd(12'h2bc);
        chk({rsp, rdv}, {pqp_pkg::PQP_RESP_SLVERR, 32'h0000_0000});
        wr(12'h284, 32'h0000_fa50);
        for (i = 0; i < 8; i++) begin
            snd(i[2:0], 1'b1, 48'h0, 16'h0040);
            wg(i + 1);
            chk(last[34:33], i[2:1]);
        end
        wr(12'h288, 32'h0000_a005);
        snd(3'h0, 1'b0, 48'h0, 16'h0040);
        wg(9);
        chk(last[34:16], {2'h2, 1'b1, 16'ha005});
        wr(12'h2a8, 32'h0000_8421);
        chk({wen, sched_weights}, {1'b1, 16'h8421});
        @(posedge core_clk);
        {tx_queue, tx_len, tx_valid} <= {2'h1, 16'h00c8, 1'b1};
        do @(negedge core_clk); while (!tx_ready);
        @(posedge core_clk);
        tx_valid <= 1'b0;
        repeat (2) @(negedge core_clk);
        chk(spages[31:16], 16'h0002);
        wr(12'h2b0, 32'h3322_1102);
        wr(12'h2b4, 32'h0000_5544);
        wr(12'h2c0, 32'h0004_0000);
        snd(3'h0, 1'b1, 48'h0211_2233_4456, 16'h0040);
        repeat (4) @(negedge core_clk);
        chk(got, 9);
        snd(3'h0, 1'b1, 48'h0211_2233_4455, 16'h0040);
        wg(10);
        chk(got, 10);
        snd(3'h0, 1'b1, 48'h0100_0000_0009, 16'h0040);
        wg(11);
        chk(got, 11);
        wr(12'h2c0, 32'h0000_0000);
        hold <= 1'b1;
        for (i = 0; i < 16; i++) snd(3'h1, 1'b1, 48'h0, 16'h0040);
        @(posedge core_clk);
        rx_valid <= 1'b1;
        @(negedge core_clk);
        chk(rx_ready, 1'b0);
        @(posedge core_clk);
        hold <= 1'b0;
        do @(negedge core_clk); while (!rx_ready);
        @(posedge core_clk);
        rx_valid <= 1'b0;
        wg(28);
        chk(got, 28);
        wr(12'h2a0, 32'h0000_0064);
        wr(12'h28c, 32'h0fff_0001);
        snd(3'h0, 1'b1, 48'h0, 16'h1000);
        repeat (2) @(negedge core_clk);
        chk(rx_ready, 1'b0);
        for (i = 0; i < 110 && !rx_ready; i++) @(negedge core_clk);
        chk(rx_ready, 1'b1);
        wr(12'h2a4, 32'h0000_1428);
        wr(12'h2c0, 32'h0000_0001);
        rx_page_count <= 8'h28;
        repeat (4) @(negedge core_clk);
        chk(pact, 1'b0);
        @(posedge core_clk);
        rx_page_count <= 8'h29;
        for (i = 0; i < 8 && !pon; i++) @(negedge core_clk);
        chk({pon, pact}, 2'b11);
        @(posedge core_clk);
        rx_page_count <= 8'h13;
        for (i = 0; i < 8 && !poff; i++) @(negedge core_clk);
        chk({poff, pact}, 2'b10);
        wr(12'h294, 32'h0000_0fff);
        chk(tx_ready, 1'b0);
        wr(12'h294, 32'h0fff_0fff);
        wr(12'h29c, 32'h0000_0fff);
        chk(tx_ready, 1'b1);
        wr(12'h2c0, 32'h0002_0000);
        chk(tx_ready, 1'b0);
        end_sim();
    end
endmodule
